/* dv/srw_ref_model.sv */
// Clock source model driving the reference as each delayed instance sees it
`timescale 1ns/1ps
module srw_ref_model
  import srw_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ref_on,
  input  wire logic             periodic,
  input  wire logic [4:0]       edge_pos,
  output logic      [23:0]      ref_tap_samples
);
  logic [3:0] div_r;
  // Period of 16 clocks stands in for a division of the frame clock
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  // Instances at or above edge_pos see it high; taps stay low otherwise
  assign ref_tap_samples = (ref_on || (periodic && div_r[3])) ?
                           (24'hff_ffff << edge_pos) : 24'h00_0000;
endmodule // srw_ref_model

/* dv/tb.sv */
// Self-checking bench for the reference window capture block
`timescale 1ns/1ps
module tb
  import srw_pkg::*;
();
  logic        clk, nrst, reg_rd_en, fine_step_control, ref_on, periodic;
  logic        delay_fine_step, ref_level, ref_capture_pulse;
  logic [3:0]  ref_sample_select;
  logic [4:0]  edge_pos;
  logic [7:0]  reg_addr, reg_rd_data, b;
  logic [23:0] ref_tap_samples, m;
  int          n_errors, cmp_count, cyc, cnt;
  int          ps[7] = '{1, 1, 8, 8, 12, 23, 16};
  int          ss[7] = '{0, 1, 7, 8, 15, 15, 15};

  srw_capture DUT (.clk, .nrst, .ref_tap_samples, .ref_sample_select,
                   .fine_step_control, .reg_rd_en, .reg_addr, .reg_rd_data,
                   .delay_fine_step, .ref_level, .ref_capture_pulse);
  srw_ref_model u_src (.clk, .nrst, .ref_on, .periodic, .edge_pos, .ref_tap_samples);

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      $display("Error %0t timeout", $time);
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access and compare tasks; inputs move 1 ns after the edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e, input string s);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // Idle tick after each read keeps strobe edges apart and checks the drop
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick();
    reg_rd_en = 1'b0;
    d = reg_rd_data;
    tick();
    chk({16'h0000, reg_rd_data}, 24'h00_0000, "read idle");
  endtask
  task automatic rd_map(output logic [23:0] v);
    rd(SRW_OFF_POS_LO, v[7:0]);
    rd(SRW_OFF_POS_MID, v[15:8]);
    rd(SRW_OFF_POS_HI, v[23:16]);
  endtask
  // Disagreeing neighbours at the step, end bits always flagged
  function automatic logic [23:0] exp_map(input int p);
    logic [23:0] v;
    v = 24'h80_0001;
    v[p] = 1'b1;
    v[p-1] = 1'b1;
    return v;
  endfunction
  // One reference pulse with the step at tap p, sampled on instance s
  task automatic shot(input int p, input int s);
    int hit;
    hit = 0;
    ref_sample_select = 4'(s);
    edge_pos = 5'(p);
    repeat (2) tick();
    ref_on = 1'b1;
    for (int k = 1; k <= 6; k++)
    begin
      tick();
      if (ref_capture_pulse === 1'b1) hit += k;
    end
    chk(24'(hit), (s >= p) ? 24'd3 : 24'd0, "capture edge");
    chk({23'h0, ref_level}, 24'(s >= p), "level");
    ref_on = 1'b0;
    repeat (4) tick();
    rd_map(m);
    chk(m, exp_map(p), "map");
    $display("test shot %0d sel %0d done", p, s);
  endtask
  task automatic print_verdict();
    $display("cmp_count=%0d n_errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {nrst, reg_rd_en, fine_step_control, ref_on, periodic} = 5'b00000;
    {ref_sample_select, edge_pos, reg_addr} = 17'h0_0000;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    rd_map(m);
    chk(m, SRW_POS_RST, "reset map");
    rd(8'h2f, b);
    chk({16'h0000, b}, 24'h00_0000, "unmapped");
    $display("test reset done");
    for (int f = 0; f < 2; f++)
    begin
      fine_step_control = 1'(f);
      repeat (2) tick();
      chk({23'h0, delay_fine_step}, 24'(f), "fine step");
    end
    $display("test fine step done");
    for (int i = 0; i < 7; i++) shot(ps[i], ss[i]);
    // Skip the first period: switching on mid-high adds a stray rise
    edge_pos = 5'd5;
    ref_sample_select = 4'd10;
    periodic = 1'b1;
    repeat (16) tick();
    cnt = 0;
    repeat (64)
    begin
      tick();
      cnt += (ref_capture_pulse === 1'b1);
    end
    chk(24'(cnt), 24'd4, "periodic pulses");
    periodic = 1'b0;
    repeat (20) tick();
    rd_map(m);
    chk(m, exp_map(5), "periodic map");
    $display("test periodic done");
    // Mid-run reset must clear the outputs and bring back the all-flagged map
    nrst = 1'b0;
    tick();
    chk({13'h0000, reg_rd_data, ref_level, ref_capture_pulse, delay_fine_step}, 24'h00_0000,
        "in reset");
    tick();
    nrst = 1'b1;
    rd_map(m);
    chk(m, SRW_POS_RST, "map after reset");
    $display("test mid reset done");
    print_verdict();
  end
endmodule // tb

/* rtl/srw_capture.sv */
// Reference window capture: position detector, sample select, status read
//
// How it works
// R01: The far side runs the periodic reference at a division of the frame clock.
// R02: A single pulse or a running periodic reference are both accepted.
// R03: The reference is caught on one known clock edge at every power-on.
// R04: Placement against the clock rising edge is measured into the status field.
// R05: A status bit of one flags a setup or hold risk; zero is valid.
// R06: Twenty-four instances, smallest delay at bit zero, largest at the top.
// R07: The lowest and highest status bits always read one.
// R08: Select holds a bit index; only indices zero to fifteen can be chosen.
// R09: Each instance is a delayed clock copy; the selected one captures the reference.
// R10: Fine-step low gives coarse delay steps, high gives finer ones.
// R11: Software should normally use fine steps unless no one-region shows.
// R12: Clock and reference must both be applied before the field is read.
// R13: Software picks the middle of the valid window, favouring low indices.
// R14: The status field refreshes on every received reference edge.
`timescale 1ns/1ps
module srw_capture
  import srw_pkg::*;
#(
  parameter int NUM_POS = SRW_NUM_POS,
  parameter int NUM_SEL = SRW_NUM_SEL
)(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [NUM_POS-1:0]   ref_tap_samples,
  input  wire logic [SRW_SEL_W-1:0] ref_sample_select,
  input  wire logic                 fine_step_control,
  input  wire logic                 reg_rd_en,
  input  wire logic [7:0]           reg_addr,
  output logic      [7:0]           reg_rd_data,
  output logic                      delay_fine_step,
  output logic                      ref_level,
  output logic                      ref_capture_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  if (NUM_POS < 3 || NUM_POS > SRW_NUM_POS)
  begin : g_bad_pos
    $error("NUM_POS must lie between 3 and 24");
  end
  if (NUM_SEL != (1 << SRW_SEL_W) || NUM_SEL > NUM_POS)
  begin : g_bad_sel
    $error("NUM_SEL must match the select width and fit in NUM_POS");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Types and functions

  typedef struct packed {
    logic [NUM_POS-1:0]    taps_d;
    logic [NUM_POS-1:0]    pos;
    logic [SRW_SEL_W-1:0]  sel;
    logic                  fine;
    logic                  lvl;
    logic                  cap;
    logic [SRW_BYTE_W-1:0] rd;
  } srw_state_s;

  localparam srw_state_s ST_RST = '{
    taps_d : '0,
    pos    : SRW_POS_RST[NUM_POS-1:0],
    sel    : SRW_SEL_RST,
    fine   : 1'b0,
    lvl    : 1'b0,
    cap    : 1'b0,
    rd     : SRW_RD_RST
  };

  // Instances next to the sampled edge disagree with a neighbour: risky
  function automatic logic [NUM_POS-1:0] srw_risk_map(input logic [NUM_POS-1:0] w);
    logic [NUM_POS-1:0] m;
    m = '0;
    for (int i = 1; i < NUM_POS - 1; i++)
    begin
      m[i] = (w[i] ^ w[i-1]) | (w[i] ^ w[i+1]);
    end
    // No neighbour on the outside, so no margin can be known there
    m[0]         = 1'b1; // R07
    m[NUM_POS-1] = 1'b1; // R07
    return m;
  endfunction

  // Pads the status field to the full three-byte map
  function automatic logic [SRW_NUM_POS-1:0] srw_widen(input logic [NUM_POS-1:0] p);
    logic [SRW_NUM_POS-1:0] f;
    f = '0;
    f[NUM_POS-1:0] = p;
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin-side taps pass two flops first

  logic [NUM_POS-1:0] taps_s;

  srw_sync #(
    .WIDTH (NUM_POS)
  ) u_tap_sync (
    .clk   (clk),
    .nrst  (nrst),
    .d_in  (ref_tap_samples),
    .q_out (taps_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  srw_state_s             st_r;
  srw_state_s             st_nxt;
  logic                   rise_any;
  logic                   rise_sel;
  logic [SRW_NUM_POS-1:0] pos_full;

  // Any tap rising marks a received reference edge; pulse or clock alike
  assign rise_any = |(taps_s & ~st_r.taps_d); // R02
  // Capture strictly on the chosen delayed instance
  assign rise_sel = taps_s[st_r.sel] & ~st_r.taps_d[st_r.sel]; // R09
  assign pos_full = srw_widen(st_r.pos);

  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.taps_d = taps_s;
    // Select is four bits wide, so only the first sixteen can be reached
    st_nxt.sel    = ref_sample_select; // R08
    st_nxt.fine   = fine_step_control; // R10
    st_nxt.lvl    = taps_s[st_r.sel]; // R09
    // One known clock edge after the selected instance rises
    st_nxt.cap    = rise_sel; // R03
    // Each edge overwrites the map so the latest placement is shown
    if (rise_any)
    begin
      st_nxt.pos = srw_risk_map(taps_s); // R04 R14
    end
    // Status read; unmapped offsets answer zero
    st_nxt.rd = SRW_RD_RST;
    if (reg_rd_en)
    begin
      case (reg_addr)
        SRW_OFF_POS_LO:  st_nxt.rd = pos_full[7:0]; // R06
        SRW_OFF_POS_MID: st_nxt.rd = pos_full[15:8]; // R06
        SRW_OFF_POS_HI:  st_nxt.rd = pos_full[23:16]; // R06
        default:         st_nxt.rd = SRW_RD_RST;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign reg_rd_data       = st_r.rd; // R05
  assign delay_fine_step   = st_r.fine; // R10
  assign ref_level         = st_r.lvl;
  assign ref_capture_pulse = st_r.cap;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_end_bits_set: assert property (st_r.pos[0] && st_r.pos[NUM_POS-1]) // R07
    else $error("outer position bits not set");

  a_pos_refresh_edge: assert property (rise_any |=> st_r.pos == srw_risk_map($past(taps_s))) // R14
    else $error("position map not refreshed on edge");

  a_pos_hold_quiet: assert property (!rise_any |=> $stable(st_r.pos)) // R04
    else $error("position map changed without an edge");

  a_capture_on_sel: assert property (rise_sel |=> ref_capture_pulse && ref_level) // R03
    else $error("selected instance edge not captured");

  a_capture_cause: assert property (
    ref_capture_pulse |-> $past(taps_s[st_r.sel]) && !$past(st_r.taps_d[st_r.sel])) // R09
    else $error("capture pulse without selected edge");

  a_capture_single: assert property (ref_capture_pulse |=> !ref_capture_pulse) // R02
    else $error("capture pulse longer than one cycle");

  a_fine_follows: assert property (
    fine_step_control != delay_fine_step |=> delay_fine_step == $past(fine_step_control)) // R10
    else $error("fine step output did not follow control");

  a_read_low_byte: assert property (
    reg_rd_en && reg_addr == SRW_OFF_POS_LO |=> reg_rd_data == $past(pos_full[7:0])) // R05
    else $error("low status byte read wrong");

  a_read_high_byte: assert property (
    reg_rd_en && reg_addr == SRW_OFF_POS_HI |=> reg_rd_data == $past(pos_full[23:16])) // R06
    else $error("high status byte read wrong");

  a_level_follows: assert property (ref_level == $past(taps_s[st_r.sel])) // R09
    else $error("level does not follow selected instance");

  c_capture_seen: cover property (ref_capture_pulse);
  c_risk_inner: cover property (rise_any ##1 (|st_r.pos[NUM_POS-2:1]));
  c_read_mid: cover property (reg_rd_en && reg_addr == SRW_OFF_POS_MID);
  c_fine_capture: cover property (delay_fine_step && ref_capture_pulse);

endmodule // srw_capture

/* rtl/srw_pkg.sv */
// Constants shared by the reference window capture block
package srw_pkg;

  // Register byte offsets of the position status field
  localparam logic [7:0]  SRW_OFF_POS_LO  = 8'h2c;
  localparam logic [7:0]  SRW_OFF_POS_MID = 8'h2d;
  localparam logic [7:0]  SRW_OFF_POS_HI  = 8'h2e;

  // Field geometry
  localparam int          SRW_NUM_POS     = 24;
  localparam int          SRW_NUM_SEL     = 16;
  localparam int          SRW_SEL_W       = 4;
  localparam int          SRW_BYTE_W      = 8;
  localparam int          SRW_SYNC_STAGES = 2;

  // Value after reset: no placement known, every instance flagged
  localparam logic [23:0] SRW_POS_RST     = 24'hff_ffff;
  localparam logic [3:0]  SRW_SEL_RST     = 4'h0;
  localparam logic [7:0]  SRW_RD_RST      = 8'h00;

endpackage : srw_pkg

/* rtl/srw_sync.sv */
// Two-stage synchroniser for a vector of pin-side levels
`timescale 1ns/1ps
module srw_sync
  import srw_pkg::*;
#(
  parameter int WIDTH = SRW_NUM_POS
)(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  // Parameter check; an empty vector has nothing to carry
  if (WIDTH < 1)
  begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } srw_sync_s;

  srw_sync_s st_r;
  srw_sync_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second one
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.meta   = d_in;
    st_nxt.stable = st_r.meta;
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r.stable;

endmodule // srw_sync
